// ---- core/fbsm_top.sv ----
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1: net state codes 1,2,4,8
// R2: mode codes 1 PP, 3 PV, 4 PT
// R3: mode code 0 none, 6 homing
// R4: mode codes 8 CSP, 9 CSV, a CST
// R5: all seven drive modes accepted
// R6: process frames only with header type 1
// R7: one header then datagrams, parsed sequentially
// R8: frame bytes forwarded unchanged
// R9: init: no sdo, txpdo, rxpdo
// R10: master sets addresses before pre-op request
// R11: pre-op: sdo only
// R12: master maps pdo before safe-op request
// R13: safe-op: sdo, txpdo; outputs ignored
// R14: master sends outputs before op request
// R15: op: sdo, txpdo, rxpdo all on
// R16: upward request only to next state
// R17: reset enters init, reports code 1
module fbsm_top (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic [3:0] req_state,
    input wire logic [7:0] mode_sel,
    input wire logic frm_start,
    input wire logic [3:0] hdr_type,
    input wire logic dgram_valid,
    input wire logic dgram_last,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rxpdo_valid,
    input wire logic [15:0] rxpdo_data,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic [3:0] net_code,
    output logic [3:0] mode_code,
    output logic sdo_en,
    output logic txpdo_en,
    output logic rxpdo_en,
    output logic [15:0] out_data,
    output logic out_valid,
    output logic frame_accept,
    output logic dgram_pulse,
    output logic frame_done
);
    typedef struct packed {
        fbsm_pkg::fbsm_state_t st;
        logic [3:0] net_code;
        logic [3:0] mode_code;
        logic sdo_en;
        logic txpdo_en;
        logic rxpdo_en;
        logic [15:0] out_data;
        logic out_valid;
        logic [7:0] tx_data;
        logic tx_valid;
        logic frame_accept;
        logic dgram_pulse;
        logic frame_done;
    } fbsm_top_t;
    fbsm_top_t s_r;
    fbsm_top_t s_nxt;

    fbsm_frm_if frm ();
    assign frm.frm_start = frm_start;
    assign frm.hdr_type = hdr_type;
    assign frm.dgram_valid = dgram_valid;
    assign frm.dgram_last = dgram_last;
    fbsm_frame_filter u_filt (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .frm(frm)
    );

    logic req_ok;
    logic req_go;
    fbsm_pkg::fbsm_state_t req_tgt;
    // illegal codes keep the target at the current state, so they change nothing
    always_comb begin
        req_ok = 1'b1;
        req_tgt = s_r.st;
        case (req_state)
            fbsm_pkg::FBSM_NET_INIT: begin
                req_tgt = fbsm_pkg::FBSM_ST_INIT;
            end
            fbsm_pkg::FBSM_NET_PREOP: begin
                req_tgt = fbsm_pkg::FBSM_ST_PREOP;
            end
            fbsm_pkg::FBSM_NET_SAFEOP: begin
                req_tgt = fbsm_pkg::FBSM_ST_SAFEOP;
            end
            fbsm_pkg::FBSM_NET_OP: begin
                req_tgt = fbsm_pkg::FBSM_ST_OP;
            end
            default: begin
                req_ok = 1'b0;
            end
        endcase
    end

    // table of legal moves: any step down, one step up
    always_comb begin
        req_go = 1'b0;
        case (s_r.st)
            fbsm_pkg::FBSM_ST_INIT: begin
                req_go = (req_tgt == fbsm_pkg::FBSM_ST_INIT)
                    || (req_tgt == fbsm_pkg::FBSM_ST_PREOP);
            end
            fbsm_pkg::FBSM_ST_PREOP: begin
                req_go = (req_tgt != fbsm_pkg::FBSM_ST_OP);
            end
            fbsm_pkg::FBSM_ST_SAFEOP: begin
                req_go = 1'b1;
            end
            fbsm_pkg::FBSM_ST_OP: begin
                req_go = 1'b1;
            end
            default: begin
                req_go = 1'b0;
            end
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        if (req_valid && req_ok && req_go) begin // see R16
            s_nxt.st = req_tgt;
        end
        case (s_nxt.st)
            fbsm_pkg::FBSM_ST_INIT: begin
                s_nxt.net_code = fbsm_pkg::FBSM_NET_INIT; // see R1
                s_nxt.sdo_en = 1'b0; // see R9
                s_nxt.txpdo_en = 1'b0;
                s_nxt.rxpdo_en = 1'b0;
            end
            fbsm_pkg::FBSM_ST_PREOP: begin
                s_nxt.net_code = fbsm_pkg::FBSM_NET_PREOP; // see R1
                s_nxt.sdo_en = 1'b1; // see R11
                s_nxt.txpdo_en = 1'b0;
                s_nxt.rxpdo_en = 1'b0;
            end
            fbsm_pkg::FBSM_ST_SAFEOP: begin
                s_nxt.net_code = fbsm_pkg::FBSM_NET_SAFEOP; // see R1
                s_nxt.sdo_en = 1'b1; // see R13
                s_nxt.txpdo_en = 1'b1;
                s_nxt.rxpdo_en = 1'b0;
            end
            fbsm_pkg::FBSM_ST_OP: begin
                s_nxt.net_code = fbsm_pkg::FBSM_NET_OP; // see R1
                s_nxt.sdo_en = 1'b1; // see R15
                s_nxt.txpdo_en = 1'b1;
                s_nxt.rxpdo_en = 1'b1;
            end
            default: begin
                s_nxt.net_code = fbsm_pkg::FBSM_NET_INIT;
                s_nxt.sdo_en = 1'b0;
                s_nxt.txpdo_en = 1'b0;
                s_nxt.rxpdo_en = 1'b0;
            end
        endcase
        case (mode_sel) // see R5
            fbsm_pkg::FBSM_MODE_SEL_PP: begin
                s_nxt.mode_code = fbsm_pkg::FBSM_MODE_PP; // see R2
            end
            fbsm_pkg::FBSM_MODE_SEL_PV: begin
                s_nxt.mode_code = fbsm_pkg::FBSM_MODE_PV;
            end
            fbsm_pkg::FBSM_MODE_SEL_PT: begin
                s_nxt.mode_code = fbsm_pkg::FBSM_MODE_PT;
            end
            fbsm_pkg::FBSM_MODE_SEL_HM: begin
                s_nxt.mode_code = fbsm_pkg::FBSM_MODE_HM; // see R3
            end
            fbsm_pkg::FBSM_MODE_SEL_CSP: begin
                s_nxt.mode_code = fbsm_pkg::FBSM_MODE_CSP; // see R4
            end
            fbsm_pkg::FBSM_MODE_SEL_CSV: begin
                s_nxt.mode_code = fbsm_pkg::FBSM_MODE_CSV;
            end
            fbsm_pkg::FBSM_MODE_SEL_CST: begin
                s_nxt.mode_code = fbsm_pkg::FBSM_MODE_CST;
            end
            default: begin
                s_nxt.mode_code = fbsm_pkg::FBSM_MODE_NONE; // see R3
            end
        endcase
        // output data only drives the axis in op; safe-op drops it
        s_nxt.out_valid = rxpdo_valid && s_r.rxpdo_en && frm.accept; // see R13
        if (s_nxt.out_valid) begin
            s_nxt.out_data = rxpdo_data; // see R15
        end
        // byte stream forwarded untouched, one cycle of latency
        s_nxt.tx_data = rx_data; // see R8
        s_nxt.tx_valid = rx_valid;
        s_nxt.frame_accept = frm.accept; // see R6
        s_nxt.dgram_pulse = frm.dgram_take; // see R7
        s_nxt.frame_done = frm.frame_done;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.st <= fbsm_pkg::FBSM_ST_INIT; // see R17
            s_r.net_code <= fbsm_pkg::FBSM_NET_INIT;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tx_data = s_r.tx_data;
    assign tx_valid = s_r.tx_valid;
    assign net_code = s_r.net_code;
    assign mode_code = s_r.mode_code;
    assign sdo_en = s_r.sdo_en;
    assign txpdo_en = s_r.txpdo_en;
    assign rxpdo_en = s_r.rxpdo_en;
    assign out_data = s_r.out_data;
    assign out_valid = s_r.out_valid;
    assign frame_accept = s_r.frame_accept;
    assign dgram_pulse = s_r.dgram_pulse;
    assign frame_done = s_r.frame_done;
endmodule : fbsm_top
`default_nettype wire

// ---- core/fbsm_pkg.sv ----
package fbsm_pkg;
    localparam logic [3:0] FBSM_NET_INIT = 4'h1;
    localparam logic [3:0] FBSM_NET_PREOP = 4'h2;
    localparam logic [3:0] FBSM_NET_SAFEOP = 4'h4;
    localparam logic [3:0] FBSM_NET_OP = 4'h8;
    localparam logic [3:0] FBSM_MODE_NONE = 4'h0;
    localparam logic [3:0] FBSM_MODE_PP = 4'h1;
    localparam logic [3:0] FBSM_MODE_PV = 4'h3;
    localparam logic [3:0] FBSM_MODE_PT = 4'h4;
    localparam logic [3:0] FBSM_MODE_HM = 4'h6;
    localparam logic [3:0] FBSM_MODE_CSP = 4'h8;
    localparam logic [3:0] FBSM_MODE_CSV = 4'h9;
    localparam logic [3:0] FBSM_MODE_CST = 4'ha;
    localparam logic [3:0] FBSM_HDR_TYPE_PROC = 4'h1;
    localparam logic [7:0] FBSM_MODE_SEL_PP = 8'h01;
    localparam logic [7:0] FBSM_MODE_SEL_PV = 8'h03;
    localparam logic [7:0] FBSM_MODE_SEL_PT = 8'h04;
    localparam logic [7:0] FBSM_MODE_SEL_HM = 8'h06;
    localparam logic [7:0] FBSM_MODE_SEL_CSP = 8'h08;
    localparam logic [7:0] FBSM_MODE_SEL_CSV = 8'h09;
    localparam logic [7:0] FBSM_MODE_SEL_CST = 8'h0a;
    typedef enum logic [1:0] {
        FBSM_ST_INIT,
        FBSM_ST_PREOP,
        FBSM_ST_SAFEOP,
        FBSM_ST_OP
    } fbsm_state_t;
endpackage : fbsm_pkg

// ---- core/fbsm_frm_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface fbsm_frm_if;
    logic frm_start;
    logic [3:0] hdr_type;
    logic dgram_valid;
    logic dgram_last;
    logic accept;
    logic dgram_take;
    logic frame_done;
    modport filt (
        input frm_start, hdr_type, dgram_valid, dgram_last,
        output accept, dgram_take, frame_done
    );
    modport top (
        output frm_start, hdr_type, dgram_valid, dgram_last,
        input accept, dgram_take, frame_done
    );
endinterface : fbsm_frm_if
`default_nettype wire

// ---- core/fbsm_frame_filter.sv ----
`timescale 1ns/1ns
`default_nettype none
module fbsm_frame_filter (
    input wire logic sys_clk,
    input wire logic sys_rst,
    fbsm_frm_if.filt frm
);
    typedef struct packed {
        logic in_frame;
        logic accept;
    } fbsm_filt_t;
    fbsm_filt_t s_r;
    fbsm_filt_t s_nxt;
    always_comb begin
        s_nxt = s_r;
        if (frm.frm_start) begin
            s_nxt.in_frame = 1'b1;
            s_nxt.accept = (frm.hdr_type == fbsm_pkg::FBSM_HDR_TYPE_PROC); // see R6
        end else if (frm.dgram_valid && frm.dgram_last) begin
            s_nxt.in_frame = 1'b0; // see R7
            s_nxt.accept = 1'b0;
        end
    end
    // datagrams counted one after another, only inside an accepted frame
    assign frm.accept = s_r.accept;
    assign frm.dgram_take = s_r.in_frame && s_r.accept && frm.dgram_valid; // see R7
    assign frm.frame_done = s_r.in_frame && frm.dgram_valid && frm.dgram_last;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : fbsm_frame_filter
`default_nettype wire

// ---- testbench/fbsm_top_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module fbsm_top_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic [3:0] req_state,
    input wire logic [7:0] mode_sel,
    input wire logic frm_start,
    input wire logic [3:0] hdr_type,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic [3:0] net_code,
    input wire logic [3:0] mode_code,
    input wire logic sdo_en,
    input wire logic txpdo_en,
    input wire logic rxpdo_en,
    input wire logic frame_accept
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    wire logic [2:0] en = {sdo_en, txpdo_en, rxpdo_en};
    a_reset_init: assert property ($fell(sys_rst) |-> net_code == 4'h1)
        else $error("not init after reset");
    a_init_quiet: assert property (net_code == 4'h1 |-> en == 3'b000)
        else $error("traffic in init");
    a_preop_mbox: assert property (net_code == 4'h2 |-> en == 3'b100)
        else $error("bad preop enables");
    a_safeop_in: assert property (net_code == 4'h4 |-> en == 3'b110)
        else $error("bad safeop enables");
    a_op_all: assert property (net_code == 4'h8 |-> en == 3'b111)
        else $error("bad op enables");
    a_step_next: assert property (req_valid && !net_code[3] &&
        req_state == {net_code[2:0], 1'b0} |=> net_code == $past(req_state))
        else $error("next state not taken");
    a_no_skip: assert property (req_valid && {1'b0, req_state} > {net_code, 1'b0}
        |=> $stable(net_code)) else $error("skip taken");
    a_mode_map: assert property (1'b1 |=> mode_code ==
        (($past(mode_sel) inside {8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0a})
        ? $past(mode_sel[3:0]) : 4'h0)) else $error("bad mode code");
    a_type_drop: assert property (frm_start && hdr_type != 4'h1 ##1 !frm_start
        |=> !frame_accept) else $error("wrong type accepted");
    a_type_take: assert property (frm_start && hdr_type == 4'h1 ##1 !frm_start
        |=> frame_accept) else $error("right type refused");
    a_pass_thru: assert property (rx_valid |=> tx_valid && tx_data == $past(rx_data))
        else $error("byte not forwarded");
endmodule : fbsm_top_chk
bind fbsm_top fbsm_top_chk u_fbsm_top_chk (.sys_clk, .sys_rst, .req_valid, .req_state,
    .mode_sel, .frm_start, .hdr_type, .rx_data, .rx_valid, .tx_data, .tx_valid, .net_code,
    .mode_code, .sdo_en, .txpdo_en, .rxpdo_en, .frame_accept);
`default_nettype wire

// ---- testbench/fbsm_master_mdl.sv ----
`timescale 1ns/1ns
`default_nettype none
module fbsm_master_mdl (
    input wire logic sys_clk,
    output logic req_valid,
    output logic [3:0] req_state,
    output logic frm_start,
    output logic [3:0] hdr_type,
    output logic dgram_valid,
    output logic dgram_last,
    output logic rxpdo_valid,
    output logic [15:0] rxpdo_data
);
    initial begin
        {req_valid, req_state, frm_start, hdr_type} = '0;
        {dgram_valid, dgram_last, rxpdo_valid, rxpdo_data} = '0;
    end
    // callers send a process frame with outputs before the safe-op and op requests that are taken
    task automatic req(input logic [3:0] s);
        @(negedge sys_clk) {req_valid, req_state} = {1'b1, s};
        @(negedge sys_clk) {req_valid, req_state} = {1'b0, ~s};
    endtask : req
    task automatic frame(input logic [3:0] t, input int n, input logic [15:0] d);
        @(negedge sys_clk) {frm_start, hdr_type} = {1'b1, t};
        @(negedge sys_clk) {frm_start, hdr_type} = {1'b0, ~t};
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk) {dgram_valid, dgram_last, rxpdo_valid} = {2'b10 | (i == n - 1), 1'b1};
            rxpdo_data = d + 16'(i);
        end
        @(negedge sys_clk) {dgram_valid, dgram_last, rxpdo_valid} = 3'b000;
        rxpdo_data = ~d;
    endtask : frame
endmodule : fbsm_master_mdl
`default_nettype wire

// ---- testbench/fbsm_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module fieldbus_slave_state_machine_tb_top;
    logic sys_clk = 1'b0;
    logic sys_rst;
    logic rx_valid;
    logic [7:0] mode_sel;
    logic [7:0] rx_data;
    logic [15:0] exp_out;
    logic req_valid, frm_start, dgram_valid, dgram_last, rxpdo_valid, tx_valid, out_valid;
    logic sdo_en, txpdo_en, rxpdo_en, frame_accept, dgram_pulse, frame_done;
    logic [3:0] req_state, hdr_type, net_code, mode_code;
    logic [15:0] rxpdo_data, out_data;
    logic [7:0] tx_data;
    int mismatches = 0;
    int comparisons = 0;
    int n_dg, n_out, n_done;
    wire logic [15:0] st = {8'h00, net_code, 1'b0, sdo_en, txpdo_en, rxpdo_en};
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        n_dg += int'(dgram_pulse);
        n_out += int'(out_valid);
        n_done += int'(frame_done);
    end
    fbsm_master_mdl u_fbsm_master_mdl (.sys_clk, .req_valid, .req_state, .frm_start,
        .hdr_type, .dgram_valid, .dgram_last, .rxpdo_valid, .rxpdo_data);
    fbsm_top u_fbsm_top (.sys_clk, .sys_rst, .req_valid, .req_state, .mode_sel, .frm_start,
        .hdr_type, .dgram_valid, .dgram_last, .rx_data, .rx_valid, .rxpdo_valid, .rxpdo_data,
        .tx_data, .tx_valid, .net_code, .mode_code, .sdo_en, .txpdo_en, .rxpdo_en, .out_data,
        .out_valid, .frame_accept, .dgram_pulse, .frame_done);
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [3:0] exp_mode(input logic [7:0] s);
        return (s inside {8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0a}) ? s[3:0] : 4'h0;
    endfunction : exp_mode
    task automatic frm(input logic [3:0] t, input int n, input logic op);
        logic [15:0] d;
        d = 16'($urandom);
        {n_dg, n_out, n_done} = '0;
        u_fbsm_master_mdl.frame(t, n, d);
        if (t == 4'h1 && op) exp_out = d + 16'(n - 1);
        repeat (2) @(negedge sys_clk);
        chk(out_data, exp_out);
        chk(16'(n_dg), (t == 4'h1) ? 16'(n) : 16'h0);
        chk(16'(n_out), (t == 4'h1 && op) ? 16'(n) : 16'h0);
        chk(16'(n_done), 16'h1);
    endtask : frm
    initial begin
        #40000;
        mismatches++;
        stop_test;
    end
    initial begin
        sys_rst = 1'b1;
        rx_valid = 1'b0;
        mode_sel = 8'h00;
        rx_data = 8'h00;
        exp_out = 16'h0000;
        void'($urandom(32'h7ee233b1));
        repeat (16) @(negedge sys_clk);
        sys_rst = 1'b0;
        chk(st, 16'h0010);
        u_fbsm_master_mdl.req(4'h3);
        chk(st, 16'h0010);
        u_fbsm_master_mdl.req(4'h4);
        chk(st, 16'h0010);
        u_fbsm_master_mdl.req(4'h2);
        chk(st, 16'h0024);
        u_fbsm_master_mdl.req(4'h8);
        chk(st, 16'h0024);
        frm(4'h1, 2, 1'b0);
        u_fbsm_master_mdl.req(4'h4);
        chk(st, 16'h0046);
        frm(4'h1, 3, 1'b0);
        u_fbsm_master_mdl.req(4'h8);
        chk(st, 16'h0087);
        frm(4'h1, 1 + int'($urandom % 4), 1'b1);
        frm(4'h1 ^ 4'(1 + $urandom % 15), 2, 1'b1);
        u_fbsm_master_mdl.req(4'h4);
        chk(st, 16'h0046);
        u_fbsm_master_mdl.req(4'h1);
        chk(st, 16'h0010);
        for (int i = 0; i < 24; i++) begin
            @(negedge sys_clk) mode_sel = (i < 16) ? 8'(i) : 8'($urandom);
            @(negedge sys_clk) chk({12'h000, mode_code}, {12'h000, exp_mode(mode_sel)});
        end
        for (int i = 0; i < 16; i++) begin
            @(negedge sys_clk) {rx_valid, rx_data} = {1'b1, 8'($urandom)};
            @(negedge sys_clk) chk({7'h00, tx_valid, tx_data}, {8'h01, rx_data});
        end
        stop_test;
    end
endmodule : fieldbus_slave_state_machine_tb_top
`default_nettype wire
